// file: common/arsc_pkg.sv
package arsc_pkg;
	// timer settings are held in hundredths of a power-system cycle
	localparam int TIME_W = 27;
	localparam logic [26:0] TIME_MAX = 27'h5F5E09C;
	localparam logic [26:0] OPEN_INTERVAL_DEFAULT = 27'h0000000;
	localparam logic [26:0] CYCLE_RESET_DEFAULT = 27'h002BF20;
	localparam logic [26:0] LOCKOUT_RESET_DEFAULT = 27'h0007530;
	localparam logic [26:0] TIMER_CLEAR = 27'h0000000;
	localparam logic [26:0] TIMER_STEP = 27'h0000001;
	localparam int SHOT_W = 3;
	localparam int INTERVALS = 4;
	localparam logic [2:0] SHOT_ZERO = 3'h0;
	localparam logic [2:0] SHOT_STEP = 3'h1;
	localparam logic [2:0] SHOT_MAX = 3'h4;
	localparam logic [2:0] ENABLE_OFF = 3'h0;
	localparam logic [2:0] ENABLE_DEFAULT = 3'h0;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_CYCLE = 2'b01,
		ST_LOCKOUT = 2'b11
	} arsc_state_type;
endpackage : arsc_pkg

// file: verilog/arsc_timer_shot.sv
module arsc_timer_shot (
	input wire logic clk,
	input wire logic rst,
	input wire logic cycle_tick,
	input wire logic settings_load,
	input wire logic [2:0] reclose_enable_count,
	input wire logic [arsc_pkg::TIME_W-1:0] open_interval_time_1,
	input wire logic [arsc_pkg::TIME_W-1:0] open_interval_time_2,
	input wire logic [arsc_pkg::TIME_W-1:0] open_interval_time_3,
	input wire logic [arsc_pkg::TIME_W-1:0] open_interval_time_4,
	input wire logic [arsc_pkg::TIME_W-1:0] cycle_reset_time,
	input wire logic [arsc_pkg::TIME_W-1:0] lockout_reset_time,
	input wire logic breaker_closed_status,
	input wire logic stall_open_timing,
	input wire logic block_reset_timing,
	input wire logic sequence_coordination,
	input wire logic reclose_initiate,
	output logic open_timing_active,
	output logic reset_timing_active,
	output logic open_interval_timeout,
	output logic shot_is_zero,
	output logic shot_is_one,
	output logic shot_is_two,
	output logic shot_is_three,
	output logic shot_is_four,
	output logic reset_state,
	output logic reclose_cycle_state,
	output logic lockout_state,
	output logic [2:0] last_shot,
	output logic [3:0] interval_available
);
	import arsc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// active settings
	logic [2:0] enable_r;
	logic [TIME_W-1:0] oi_r [INTERVALS];
	logic [TIME_W-1:0] cyc_rst_r;
	logic [TIME_W-1:0] lo_rst_r;

	function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] t);
		clamp_time = (t > TIME_MAX) ? TIME_MAX : t;
	endfunction : clamp_time

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_r <= ENABLE_DEFAULT;
			oi_r[0] <= OPEN_INTERVAL_DEFAULT;
			oi_r[1] <= OPEN_INTERVAL_DEFAULT;
			oi_r[2] <= OPEN_INTERVAL_DEFAULT;
			oi_r[3] <= OPEN_INTERVAL_DEFAULT;
			cyc_rst_r <= CYCLE_RESET_DEFAULT;
			lo_rst_r <= LOCKOUT_RESET_DEFAULT;
		end else if (settings_load) begin
			enable_r <= (reclose_enable_count > SHOT_MAX) ? SHOT_MAX : reclose_enable_count;
			oi_r[0] <= clamp_time(open_interval_time_1);
			oi_r[1] <= clamp_time(open_interval_time_2);
			oi_r[2] <= clamp_time(open_interval_time_3);
			oi_r[3] <= clamp_time(open_interval_time_4);
			cyc_rst_r <= clamp_time(cycle_reset_time);
			lo_rst_r <= clamp_time(lockout_reset_time);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// usable intervals and last shot
	logic [3:0] usable;
	logic defeated;

	genvar gi;
	generate
		for (gi = 0; gi < INTERVALS; gi++) begin : g_avail
			assign interval_available[gi] = (3'(gi) < enable_r);
			if (gi == 0) begin : g_first
				assign usable[gi] = interval_available[gi] && (oi_r[gi] != TIMER_CLEAR);
			end else begin : g_next
				assign usable[gi] = usable[gi-1] && interval_available[gi]
					&& (oi_r[gi] != TIMER_CLEAR);
			end
		end
	endgenerate

	always_comb begin
		last_shot = SHOT_ZERO;
		for (int i = 0; i < INTERVALS; i++) begin
			if (usable[i]) begin
				last_shot = 3'(i + 1);
			end
		end
	end

	assign defeated = (enable_r == ENABLE_OFF) || (last_shot == SHOT_ZERO);

	function automatic logic [TIME_W-1:0] interval_of(input logic [2:0] s,
			input logic [TIME_W-1:0] t0, input logic [TIME_W-1:0] t1,
			input logic [TIME_W-1:0] t2, input logic [TIME_W-1:0] t3);
		case (s)
			3'h0: interval_of = t0;
			3'h1: interval_of = t1;
			3'h2: interval_of = t2;
			3'h3: interval_of = t3;
			default: interval_of = TIMER_CLEAR;
		endcase
	endfunction : interval_of

	////////////////////////////////////////////////////////////////////////
	// initiation edge
	logic ri_d_r;
	logic ri_edge;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ri_d_r <= 1'b1;
		end else begin
			ri_d_r <= reclose_initiate;
		end
	end

	assign ri_edge = reclose_initiate && !ri_d_r;

	////////////////////////////////////////////////////////////////////////
	// state, arming and shot counter
	arsc_state_type state_r;
	arsc_state_type state_nxt;
	logic armed_r;
	logic [2:0] shot_r;
	logic use_lockout_r;
	logic [TIME_W-1:0] open_cnt_r;
	logic [TIME_W-1:0] rst_cnt_r;
	logic [TIME_W-1:0] open_limit;
	logic [TIME_W-1:0] rst_limit;
	logic open_run;
	logic open_done;
	logic rst_run;
	logic rst_done;

	assign open_run = !defeated && (state_r == ST_CYCLE) && armed_r
		&& !breaker_closed_status && !stall_open_timing;
	assign open_limit = interval_of(shot_r, oi_r[0], oi_r[1], oi_r[2], oi_r[3]);
	assign open_done = open_run && cycle_tick && (open_cnt_r + TIMER_STEP >= open_limit);

	assign rst_limit = (use_lockout_r || state_r == ST_LOCKOUT) ? lo_rst_r : cyc_rst_r;
	// after power-up or a settings change the reset timer also runs in reset state
	assign rst_run = !defeated && (state_r != ST_RESET || use_lockout_r) && breaker_closed_status
		&& !armed_r && !block_reset_timing;
	assign rst_done = rst_run && cycle_tick && (rst_cnt_r + TIMER_STEP >= rst_limit);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: begin
				if (ri_edge && shot_r >= last_shot) begin
					state_nxt = ST_LOCKOUT;
				end else if (ri_edge) begin
					state_nxt = ST_CYCLE;
				end else if (!breaker_closed_status) begin
					state_nxt = ST_LOCKOUT;
				end
			end
			ST_CYCLE: begin
				if (ri_edge && (open_run || armed_r)) begin
					state_nxt = ST_LOCKOUT;
				end else if (ri_edge && shot_r >= last_shot) begin
					state_nxt = ST_LOCKOUT;
				end else if (!armed_r && !breaker_closed_status && shot_r >= last_shot) begin
					state_nxt = ST_LOCKOUT;
				end else if (rst_done) begin
					state_nxt = ST_RESET;
				end
			end
			ST_LOCKOUT: begin
				if (rst_done) begin
					state_nxt = ST_RESET;
				end
			end
			default: state_nxt = ST_LOCKOUT;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_LOCKOUT;
		end else if (defeated) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_r <= 1'b0;
		end else if (defeated || state_nxt != ST_CYCLE || open_done) begin
			armed_r <= 1'b0;
		end else if (ri_edge) begin
			armed_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shot_r <= SHOT_ZERO;
		end else if (settings_load) begin
			shot_r <= SHOT_MAX;
		end else if (defeated || (state_nxt == ST_RESET && (state_r != ST_RESET || rst_done))) begin
			shot_r <= SHOT_ZERO;
		end else if (open_done && shot_r < last_shot) begin
			shot_r <= shot_r + SHOT_STEP;
		end else if (sequence_coordination && shot_r < SHOT_MAX) begin
			shot_r <= shot_r + SHOT_STEP;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			use_lockout_r <= 1'b1;
		end else if (settings_load) begin
			use_lockout_r <= 1'b1;
		end else if (rst_done) begin
			use_lockout_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			open_cnt_r <= TIMER_CLEAR;
		end else if (!armed_r || open_done || state_r != ST_CYCLE) begin
			open_cnt_r <= TIMER_CLEAR;
		end else if (open_run && cycle_tick) begin
			open_cnt_r <= open_cnt_r + TIMER_STEP;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_cnt_r <= TIMER_CLEAR;
		end else if (!breaker_closed_status || (state_r == ST_RESET && !use_lockout_r) || rst_done
			|| settings_load) begin
			rst_cnt_r <= TIMER_CLEAR;
		end else if (rst_run && cycle_tick) begin
			rst_cnt_r <= rst_cnt_r + TIMER_STEP;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			open_interval_timeout <= 1'b0;
		end else begin
			open_interval_timeout <= open_done;
		end
	end

	assign open_timing_active = open_run;
	assign reset_timing_active = rst_run;
	assign shot_is_zero = !defeated && (shot_r == 3'h0);
	assign shot_is_one = !defeated && (shot_r == 3'h1);
	assign shot_is_two = !defeated && (shot_r == 3'h2);
	assign shot_is_three = !defeated && (shot_r == 3'h3);
	assign shot_is_four = !defeated && (shot_r == 3'h4);
	assign reset_state = !defeated && (state_r == ST_RESET);
	assign reclose_cycle_state = !defeated && (state_r == ST_CYCLE);
	assign lockout_state = !defeated && (state_r == ST_LOCKOUT);

	////////////////////////////////////////////////////////////////////////
	// checks
	a_open_flag_cycle: assert property (@(posedge clk) disable iff (rst)
		open_timing_active |-> reclose_cycle_state && !breaker_closed_status && !stall_open_timing)
		else $error("open timing outside cycle state");
	a_stall_holds: assert property (@(posedge clk) disable iff (rst)
		stall_open_timing && !settings_load |=> $stable(open_cnt_r) || open_cnt_r == TIMER_CLEAR)
		else $error("open timer moved while stalled");
	a_shot_step: assert property (@(posedge clk) disable iff (rst)
		open_done && shot_r < last_shot && !settings_load |=> shot_r == $past(shot_r) + SHOT_STEP)
		else $error("shot did not advance on expiry");
	a_shot_capped: assert property (@(posedge clk) disable iff (rst)
		open_done && !settings_load |=> shot_r <= $past(last_shot))
		else $error("shot passed last shot");
	a_shot_clear: assert property (@(posedge clk) disable iff (rst)
		$rose(reset_state) && !$past(settings_load) |-> shot_is_zero)
		else $error("shot not zero in reset state");
	a_shot_onehot: assert property (@(posedge clk) disable iff (rst)
		!defeated |-> $onehot({shot_is_zero, shot_is_one, shot_is_two, shot_is_three,
			shot_is_four}))
		else $error("shot bits not one-hot");
	a_ri_lockout: assert property (@(posedge clk) disable iff (rst)
		ri_edge && open_timing_active && !defeated |=> lockout_state || defeated)
		else $error("initiation during open timing missed lockout");
	a_reset_qual: assert property (@(posedge clk) disable iff (rst)
		!reset_state ##1 reset_state && !defeated |-> $past(breaker_closed_status))
		else $error("reset state without closed breaker");
	a_block_reset: assert property (@(posedge clk) disable iff (rst)
		block_reset_timing && breaker_closed_status && !settings_load
		|=> $stable(rst_cnt_r) || rst_cnt_r == TIMER_CLEAR)
		else $error("reset timer moved while blocked");
	a_defeat_bits: assert property (@(posedge clk) disable iff (rst)
		enable_r == ENABLE_OFF |-> !reset_state && !lockout_state && !shot_is_zero
			&& !open_timing_active)
		else $error("defeated block shows activity");
endmodule : arsc_timer_shot

// file: testbench/arsc_breaker_model.sv
module arsc_breaker_model #(
	parameter int OPEN_DELAY = 2,
	parameter int CLOSE_DELAY = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic trip,
	input wire logic close_request,
	input wire logic manual_close,
	output logic breaker_closed_status
);
	timeunit 1ns;
	timeprecision 1ps;
	int open_cnt_r;
	int close_cnt_r;
	logic closing_r;
	////////////////////////////////////////////////////////////////
	// trip opens after a delay, reclose or manual close shuts it again
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			breaker_closed_status <= 1'b1;
			open_cnt_r <= 0;
			close_cnt_r <= 0;
			closing_r <= 1'b0;
		end else begin
			if (trip && breaker_closed_status && !closing_r) begin
				if (open_cnt_r == OPEN_DELAY - 1) begin
					breaker_closed_status <= 1'b0;
					open_cnt_r <= 0;
				end else begin
					open_cnt_r <= open_cnt_r + 1;
				end
			end else begin
				open_cnt_r <= 0;
			end
			if (close_request || manual_close) begin
				closing_r <= 1'b1;
				close_cnt_r <= 0;
			end else if (closing_r) begin
				if (close_cnt_r == CLOSE_DELAY - 1) begin
					breaker_closed_status <= 1'b1;
					closing_r <= 1'b0;
				end else begin
					close_cnt_r <= close_cnt_r + 1;
				end
			end
		end
	end
endmodule : arsc_breaker_model

// file: testbench/arsc_timer_shot_tb.sv
module arsc_timer_shot_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import arsc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, tk = 1'b0, ld = 1'b0, stl = 1'b0, blk = 1'b0, seq = 1'b0;
	logic ri = 1'b0, trip = 1'b0, mcl = 1'b0, brk, opt, rtm, tmo, rs, cy, lo;
	logic [2:0] en = 3'h0;
	logic [2:0] last;
	logic [3:0] avail;
	logic [4:0] sh;
	logic [TIME_W-1:0] oi1 = '0, oi2 = '0, oi3 = '0, oi4 = '0, crt = '0, lrt = '0;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	always #10 clk = ~clk;
	arsc_timer_shot i_dut (.clk(clk), .rst(rst), .cycle_tick(tk), .settings_load(ld),
		.reclose_enable_count(en), .open_interval_time_1(oi1), .open_interval_time_2(oi2),
		.open_interval_time_3(oi3), .open_interval_time_4(oi4), .cycle_reset_time(crt),
		.lockout_reset_time(lrt), .breaker_closed_status(brk), .stall_open_timing(stl),
		.block_reset_timing(blk), .sequence_coordination(seq), .reclose_initiate(ri),
		.open_timing_active(opt), .reset_timing_active(rtm), .open_interval_timeout(tmo),
		.shot_is_zero(sh[0]), .shot_is_one(sh[1]), .shot_is_two(sh[2]),
		.shot_is_three(sh[3]), .shot_is_four(sh[4]), .reset_state(rs),
		.reclose_cycle_state(cy), .lockout_state(lo), .last_shot(last),
		.interval_available(avail));
	arsc_breaker_model i_brk (.clk(clk), .rst(rst), .trip(trip), .close_request(tmo),
		.manual_close(mcl), .breaker_closed_status(brk));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic ticks(input int n);
		repeat (n) begin
			tk = 1'b1;
			@(negedge clk);
			tk = 1'b0;
			@(negedge clk);
		end
	endtask : ticks
	task automatic wait_brk(input logic v);
		for (int i = 0; i < 20 && brk !== v; i++) @(negedge clk);
		chk("breaker", brk, v);
	endtask : wait_brk
	task automatic rise_ri;
		@(negedge clk);
		ri = 1'b1;
		trip = 1'b1;
		@(negedge clk);
	endtask : rise_ri
	task automatic close_after_lockout;
		@(negedge clk);
		ri = 1'b0;
		trip = 1'b0;
		mcl = 1'b1;
		@(negedge clk);
		mcl = 1'b0;
		wait_brk(1'b1);
		@(negedge clk);
		chk("rst_timing", rtm, 1'b1);
		ticks(9);
		chk("still_lo", lo, 1'b1);
		ticks(1);
		chk("state", {lo, cy, rs}, 3'b001);
		chk("shot", sh, 5'h01);
	endtask : close_after_lockout
	// one open interval of n ticks, stalled for a while first
	task automatic open_shot(input int n, input logic [4:0] pre, input logic [4:0] post);
		logic got;
		got = 1'b0;
		rise_ri();
		chk("state", {lo, cy, rs}, 3'b010);
		wait_brk(1'b0);
		@(negedge clk);
		chk("opt", opt, 1'b1);
		stl = 1'b1;
		ticks(n + 1);
		chk("opt_stall", opt, 1'b0);
		chk("shot", sh, pre);
		stl = 1'b0;
		ticks(n - 1);
		chk("shot", sh, pre);
		tk = 1'b1;
		@(negedge clk);
		tk = 1'b0;
		for (int i = 0; i < 6 && !got; i++) begin
			got = (tmo === 1'b1);
			if (!got) @(negedge clk);
		end
		chk("timeout", got, 1'b1);
		@(negedge clk);
		chk("shot", sh, post);
		chk("opt_done", opt, 1'b0);
		ri = 1'b0;
		trip = 1'b0;
		wait_brk(1'b1);
	endtask : open_shot
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("defeated", {lo, cy, rs, sh, opt, rtm, tmo}, 11'h000);
		en = 3'h2;
		oi1 = 27'h0000003;
		oi2 = 27'h0000005;
		oi4 = 27'h0000007;
		crt = 27'h0000014;
		lrt = 27'h000000A;
		ld = 1'b1;
		@(negedge clk);
		ld = 1'b0;
		@(negedge clk);
		chk("last_shot", last, 3'h2);
		chk("avail", avail, 4'h3);
		chk("shot", sh, 5'h10);
		chk("rst_timing", rtm, 1'b1);
		ticks(9);
		blk = 1'b1;
		ticks(5);
		chk("blocked", {rtm, rs}, 2'b01);
		blk = 1'b0;
		ticks(1);
		chk("state", {lo, cy, rs}, 3'b001);
		chk("shot", sh, 5'h01);
		$display("test settings_and_reset done");
		open_shot(3, 5'h01, 5'h02);
		open_shot(5, 5'h02, 5'h04);
		rise_ri();
		chk("state", {lo, cy, rs}, 3'b100);
		chk("shot", sh, 5'h04);
		close_after_lockout();
		$display("test full_sequence done");
		rise_ri();
		wait_brk(1'b0);
		@(negedge clk);
		chk("opt", opt, 1'b1);
		ri = 1'b0;
		@(negedge clk);
		ri = 1'b1;
		@(negedge clk);
		chk("state", {lo, cy, rs, opt}, 4'b1000);
		close_after_lockout();
		$display("test reinitiate_lockout done");
		repeat (5) begin
			seq = 1'b1;
			@(negedge clk);
			seq = 1'b0;
			@(negedge clk);
			if (sh[3] === 1'b1) chk("seq_shot", rs, 1'b1);
		end
		chk("shot", sh, 5'h10);
		en = 3'h4;
		ld = 1'b1;
		@(negedge clk);
		ld = 1'b0;
		@(negedge clk);
		chk("last_shot_gap", last, 3'h2);
		chk("avail_all", avail, 4'hF);
		chk("rst_timing_load", rtm, 1'b1);
		en = 3'h0;
		ld = 1'b1;
		@(negedge clk);
		ld = 1'b0;
		@(negedge clk);
		chk("disabled", {lo, cy, rs, sh}, 8'h00);
		$display("test coordination_and_disable done");
		stop_test();
	end
endmodule : arsc_timer_shot_tb
